// >>> logic/hbctl_drive_fix.sv
// hbctl_drive_fix.sv: sanitises one channel's drive pair before it reaches the pins.
// assumes a pair already registered by the caller; purely combinational.
`timescale 1ns/10ps
module hbctl_drive_fix (
  input wire hbctl_pkg::hbctl_pair_t req,
  input wire logic parallel,
  output hbctl_pkg::hbctl_pair_t fixed,
  output logic bad_code
);
  // both high is unused outside paralleled mode; fall back to the damped state
  wire both_high = req.a & req.b & ~parallel;
  wire hbctl_pkg::hbctl_pair_t no_both = both_high ? '0 : req;
  // paralleled bridges must see identical inputs
  assign fixed.a = no_both.a;
  assign fixed.b = parallel ? no_both.a : no_both.b;
  assign bad_code = both_high | (parallel & (req.a != req.b));
endmodule // hbctl_drive_fix

// >>> logic/hbctl_map.svh
// hbctl_map.svh: register offsets, field positions and timing counts of the half-bridge controller.
// assumes inclusion by bare name from the controller top module and the bench.
`ifndef HBCTL_MAP_SVH
`define HBCTL_MAP_SVH
`define HBCTL_CLK_NS 100
// register word offsets (byte addresses)
`define HBCTL_OFF_CTRL 12'h000
`define HBCTL_OFF_DRIVE 12'h004
`define HBCTL_OFF_STAT 12'h008
`define HBCTL_OFF_IRQ_STAT 12'h00C
`define HBCTL_OFF_IRQ_CLR 12'h010
`define HBCTL_OFF_IRQ_EN 12'h014
`define HBCTL_OFF_RECOV 12'h018
// ctrl fields
`define HBCTL_CTRL_ENABLE 0
`define HBCTL_CTRL_AUTO 1
`define HBCTL_CTRL_PARALLEL 2
`define HBCTL_CTRL_RESTART 3
// status / irq fields
`define HBCTL_ST_FAULT 0
`define HBCTL_ST_WARN 1
`define HBCTL_ST_BADCODE 2
`define HBCTL_ST_RESTARTED 3
`define HBCTL_IRQ_W 4
// power-up hold-off in ns, count derived by rounding up
`define HBCTL_SETTLE_NS 100000
`define HBCTL_SETTLE_CYC ((`HBCTL_SETTLE_NS + `HBCTL_CLK_NS - 1) / `HBCTL_CLK_NS)
// float low phase used for a latched-fault restart, in ns
`define HBCTL_LOWPH_NS 1000
`define HBCTL_LOWPH_CYC ((`HBCTL_LOWPH_NS + `HBCTL_CLK_NS - 1) / `HBCTL_CLK_NS)
`define HBCTL_RECOV_RST 16'h0064
`endif

// >>> logic/hbctl_pkg.sv
// hbctl_pkg.sv: types shared by the half-bridge controller modules.
// assumes nothing beyond the map header.
package hbctl_pkg;
  typedef struct packed {
    logic a;
    logic b;
  } hbctl_pair_t;
  typedef struct packed {
    hbctl_pair_t left;
    hbctl_pair_t right;
  } hbctl_drive_t;
  typedef enum logic [2:0] {
    HBCTL_POWERUP,
    HBCTL_RUN,
    HBCTL_FAULTED,
    HBCTL_LOWPH,
    HBCTL_AUTOWAIT
  } hbctl_state_t;
endpackage

// >>> logic/hbctl_top.sv
// hbctl_top.sv: controller that drives a quad half-bridge stage through its logic pins.
// assumes the stage's fault and warning pins are open drain, pulled up and synchronous to aclk.
`timescale 1ns/10ps
`include "hbctl_map.svh"
module hbctl_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic left_drive_a,
  output logic left_drive_b,
  output logic right_drive_a,
  output logic right_drive_b,
  output logic power_down_n,
  output logic parallel_sel,
  input wire logic fault_n_in,
  output logic fault_n_out,
  output logic fault_n_oe,
  input wire logic overtemp_warn_n,
  output logic irq
);
  logic [3:0] ctrl_r;
  hbctl_pkg::hbctl_drive_t drive_r;
  logic [15:0] recov_r;
  logic [`HBCTL_IRQ_W-1:0] ist_r;
  logic [`HBCTL_IRQ_W-1:0] ien_r;
  hbctl_pkg::hbctl_state_t st_r;
  logic [15:0] cnt_r;
  logic fault_q_r;
  logic warn_q_r;
  logic self_pull_q_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  hbctl_pkg::hbctl_drive_t pins_r;
  logic float_r;

  // write path: address and data may arrive in either order
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire [11:0] rd_addr = s_axi_araddr;
  wire rd_take = s_axi_arvalid & s_axi_arready;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  wire wr_ctrl = wr_go & hit(awaddr_r, `HBCTL_OFF_CTRL) & wstrb_r[0];
  wire wr_drive = wr_go & hit(awaddr_r, `HBCTL_OFF_DRIVE) & wstrb_r[0];
  wire wr_clr = wr_go & hit(awaddr_r, `HBCTL_OFF_IRQ_CLR) & wstrb_r[0];
  wire wr_en = wr_go & hit(awaddr_r, `HBCTL_OFF_IRQ_EN) & wstrb_r[0];
  wire wr_recov = wr_go & hit(awaddr_r, `HBCTL_OFF_RECOV) & (wstrb_r[1:0] == 2'b11);
  wire wr_known = hit(awaddr_r, `HBCTL_OFF_CTRL) | hit(awaddr_r, `HBCTL_OFF_DRIVE)
                | hit(awaddr_r, `HBCTL_OFF_IRQ_CLR) | hit(awaddr_r, `HBCTL_OFF_IRQ_EN)
                | hit(awaddr_r, `HBCTL_OFF_RECOV) | hit(awaddr_r, `HBCTL_OFF_STAT)
                | hit(awaddr_r, `HBCTL_OFF_IRQ_STAT);

  // drive sanitising per channel
  hbctl_pkg::hbctl_drive_t fixed;
  logic bad_l;
  logic bad_r;
  hbctl_drive_fix u_fix_l (.req(drive_r.left), .parallel(ctrl_r[`HBCTL_CTRL_PARALLEL]), .fixed(fixed.left),
    .bad_code(bad_l));
  hbctl_drive_fix u_fix_r (.req(drive_r.right), .parallel(ctrl_r[`HBCTL_CTRL_PARALLEL]), .fixed(fixed.right),
    .bad_code(bad_r));

  // stage fault and warning as seen by the controller
  // our own pull on the shared node is no stage fault, else self-restart never ends
  wire fault_seen = fault_q_r & ~self_pull_q_r;
  wire auto_mode = ctrl_r[`HBCTL_CTRL_AUTO];
  wire restart_req = wr_ctrl & wdata_r[`HBCTL_CTRL_RESTART];
  wire cnt_done = (cnt_r == 16'h0000);

  // state machine around the float control
  hbctl_pkg::hbctl_state_t st_nxt;
  logic [15:0] cnt_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
    case (st_r)
      hbctl_pkg::HBCTL_POWERUP: if (cnt_done) begin
        st_nxt = hbctl_pkg::HBCTL_RUN;
      end
      hbctl_pkg::HBCTL_RUN: if (fault_seen) begin
        st_nxt = auto_mode ? hbctl_pkg::HBCTL_AUTOWAIT : hbctl_pkg::HBCTL_FAULTED;
        cnt_nxt = recov_r;
      end
      hbctl_pkg::HBCTL_FAULTED: if (restart_req) begin
        st_nxt = hbctl_pkg::HBCTL_LOWPH;
        cnt_nxt = 16'(`HBCTL_LOWPH_CYC);
      end
      hbctl_pkg::HBCTL_LOWPH: if (cnt_done) begin
        st_nxt = hbctl_pkg::HBCTL_RUN;
      end
      hbctl_pkg::HBCTL_AUTOWAIT: if (cnt_done) begin
        // retries forever while the fault stays; each retry re-enters this wait
        st_nxt = hbctl_pkg::HBCTL_RUN;
      end
      default: st_nxt = hbctl_pkg::HBCTL_POWERUP;
    endcase
  end

  // float high only when running and enabled; low during power-up and restart phases
  wire float_nxt = (st_nxt == hbctl_pkg::HBCTL_RUN) & ctrl_r[`HBCTL_CTRL_ENABLE];
  // in self-restart the controller also pulls the shared fault node low while waiting
  wire pull_nxt = (st_nxt == hbctl_pkg::HBCTL_AUTOWAIT);

  wire [`HBCTL_IRQ_W-1:0] ev = {(st_r == hbctl_pkg::HBCTL_AUTOWAIT) & cnt_done, bad_l | bad_r,
                                ~warn_q_r, fault_seen & (st_r == hbctl_pkg::HBCTL_RUN)};
  wire [`HBCTL_IRQ_W-1:0] ist_nxt = ev | (ist_r & ~(wr_clr ? wdata_r[`HBCTL_IRQ_W-1:0] : '0));

  wire [31:0] rd_mux =
    hit(rd_addr, `HBCTL_OFF_CTRL) ? {28'h000_0000, ctrl_r} :
    hit(rd_addr, `HBCTL_OFF_DRIVE) ? {28'h000_0000, drive_r} :
    hit(rd_addr, `HBCTL_OFF_STAT) ? {25'h000_0000, st_r, 2'b00, ~warn_q_r, fault_q_r} :
    hit(rd_addr, `HBCTL_OFF_IRQ_STAT) ? {28'h000_0000, ist_r} :
    hit(rd_addr, `HBCTL_OFF_IRQ_EN) ? {28'h000_0000, ien_r} :
    hit(rd_addr, `HBCTL_OFF_RECOV) ? {16'h0000, recov_r} : 32'h0000_0000;
  wire rd_known = hit(rd_addr, `HBCTL_OFF_CTRL) | hit(rd_addr, `HBCTL_OFF_DRIVE) | hit(rd_addr, `HBCTL_OFF_STAT)
                | hit(rd_addr, `HBCTL_OFF_IRQ_STAT) | hit(rd_addr, `HBCTL_OFF_IRQ_EN)
                | hit(rd_addr, `HBCTL_OFF_RECOV) | hit(rd_addr, `HBCTL_OFF_IRQ_CLR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 4'h0;
      drive_r <= '0;
      recov_r <= `HBCTL_RECOV_RST;
      ist_r <= '0;
      ien_r <= '0;
      st_r <= hbctl_pkg::HBCTL_POWERUP;
      cnt_r <= 16'(`HBCTL_SETTLE_CYC);
      fault_q_r <= 1'b0;
      self_pull_q_r <= 1'b0;
      warn_q_r <= 1'b1;
      pins_r <= '0;
      float_r <= 1'b0;
      fault_n_oe <= 1'b1;
      irq <= 1'b0;
    end else begin
      ctrl_r <= {1'b0, wr_ctrl ? wdata_r[2:0] : ctrl_r[2:0]};
      if (wr_drive) drive_r <= wdata_r[3:0];
      if (wr_recov) recov_r <= wdata_r[15:0];
      if (wr_en) ien_r <= wdata_r[`HBCTL_IRQ_W-1:0];
      ist_r <= ist_nxt; // set wins over clear
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      fault_q_r <= ~fault_n_in;
      self_pull_q_r <= ~fault_n_oe;
      warn_q_r <= overtemp_warn_n;
      pins_r <= fixed;
      float_r <= float_nxt;
      fault_n_oe <= ~pull_nxt;
      irq <= |(ist_nxt & ien_r);
    end
  end

  assign left_drive_a = pins_r.left.a;
  assign left_drive_b = pins_r.left.b;
  assign right_drive_a = pins_r.right.a;
  assign right_drive_b = pins_r.right.b;
  assign power_down_n = float_r;
  assign parallel_sel = ctrl_r[`HBCTL_CTRL_PARALLEL];
  assign fault_n_out = 1'b0;

  // bus slave: one write and one read at a time, answer one cycle after both halves held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_awready <= ~aw_hold_r & ~aw_take & ~s_axi_bvalid;
      s_axi_wready <= ~w_hold_r & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // assertions
  property p_never_both_high;
    @(posedge aclk) disable iff (!aresetn)
      !$past(ctrl_r[`HBCTL_CTRL_PARALLEL]) |-> !(left_drive_a & left_drive_b) && !(right_drive_a & right_drive_b);
  endproperty
  a_never_both_high: assert property (p_never_both_high) else $error("unused drive code issued");
  property p_powerup_float_low;
    @(posedge aclk) disable iff (!aresetn) (st_r == hbctl_pkg::HBCTL_POWERUP) |-> !power_down_n;
  endproperty
  a_powerup_float_low: assert property (p_powerup_float_low) else $error("float high during power-up");
  property p_parallel_equal;
    @(posedge aclk) disable iff (!aresetn)
      $past(ctrl_r[`HBCTL_CTRL_PARALLEL]) |-> (left_drive_a == left_drive_b) && (right_drive_a == right_drive_b);
  endproperty
  a_parallel_equal: assert property (p_parallel_equal) else $error("parallel inputs differ");
  sequence s_restart_low;
    (st_r == hbctl_pkg::HBCTL_FAULTED) ##1 (st_r == hbctl_pkg::HBCTL_LOWPH);
  endsequence
  property p_restart_toggle;
    @(posedge aclk) disable iff (!aresetn) s_restart_low |-> !power_down_n [*2];
  endproperty
  a_restart_toggle: assert property (p_restart_toggle) else $error("no low phase on restart");
  property p_fault_stops;
    @(posedge aclk) disable iff (!aresetn)
      (st_r == hbctl_pkg::HBCTL_RUN && fault_seen) |=> !power_down_n;
  endproperty
  a_fault_stops: assert property (p_fault_stops) else $error("float stays high on fault");
  property p_auto_pull;
    @(posedge aclk) disable iff (!aresetn) (st_r == hbctl_pkg::HBCTL_AUTOWAIT) |-> !fault_n_oe;
  endproperty
  a_auto_pull: assert property (p_auto_pull) else $error("fault node not pulled in self-restart");
  property p_auto_retry;
    @(posedge aclk) disable iff (!aresetn)
      (st_r == hbctl_pkg::HBCTL_AUTOWAIT && cnt_done) |=> (st_r == hbctl_pkg::HBCTL_RUN);
  endproperty
  a_auto_retry: assert property (p_auto_retry) else $error("self-restart does not retry");
  property p_latched_holds;
    @(posedge aclk) disable iff (!aresetn) (st_r == hbctl_pkg::HBCTL_FAULTED && !restart_req) |=>
      (st_r == hbctl_pkg::HBCTL_FAULTED) && !power_down_n;
  endproperty
  a_latched_holds: assert property (p_latched_holds) else $error("latched fault released early");
endmodule // hbctl_top

// >>> tb/hbctl_stage_model.sv
// hbctl_stage_model.sv: behavioural quad half-bridge stage facing the controller's pins.
// assumes the bench resolves the open-drain fault node and drives the fault, heat and supply conditions.
`timescale 1ns/10ps
module hbctl_stage_model (
  input wire logic [3:0] drv,
  input wire logic power_down_n,
  input wire logic fault_cond,
  input wire logic hot,
  input wire logic undervolt,
  output logic fault_pull,
  output logic overtemp_warn_n,
  output logic [7:0] sw
);
  logic latch_r;
  logic live;
  // the stage has no clock, so the fault latch is level sensitive
  always @* begin
    if (!power_down_n) latch_r = 1'b0;
    else if (fault_cond) latch_r = 1'b1;
  end
  assign fault_pull = latch_r;
  assign overtemp_warn_n = !hot;
  // undervoltage holds no state, so recovery needs no action
  assign live = power_down_n && !latch_r && !undervolt;
  // per channel: upper_switch_a, upper_switch_b, lower_switch_a, lower_switch_b
  assign sw[7:4] = live ? {drv[3], drv[2], !drv[3], !drv[2]} : 4'h0;
  assign sw[3:0] = live ? {drv[1], drv[0], !drv[1], !drv[0]} : 4'h0;
endmodule // hbctl_stage_model

// >>> tb/test_half_bridge_gate_decode_fault.sv
// test_half_bridge_gate_decode_fault.sv: bench for the controller driving a stage model.
// assumes map header, package and design files are compiled first.
`timescale 1ns/10ps
`include "hbctl_map.svh"
module test_half_bridge_gate_decode_fault;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, drv;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic power_down_n, parallel_sel, fault_n_out, fault_n_oe, warn_n, irq, fault_pull, fault_cond, hot, undervolt;
  logic [7:0] sw;
  wire logic fault_node;
  int mismatches, compares, cyc;
  // open drain node, pulled up unless either party sinks it
  assign fault_node = !fault_pull && (fault_n_oe || fault_n_out);
  hbctl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .left_drive_a(drv[3]), .left_drive_b(drv[2]), .right_drive_a(drv[1]), .right_drive_b(drv[0]),
    .power_down_n(power_down_n), .parallel_sel(parallel_sel), .fault_n_in(fault_node), .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe), .overtemp_warn_n(warn_n), .irq(irq));
  hbctl_stage_model stage (.drv(drv), .power_down_n(power_down_n), .fault_cond(fault_cond), .hot(hot),
    .undervolt(undervolt), .fault_pull(fault_pull), .overtemp_warn_n(warn_n), .sw(sw));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
  function automatic logic [7:0] swx(input logic [3:0] d);
    return {d[3], d[2], !d[3], !d[2], d[1], d[0], !d[1], !d[0]};
  endfunction
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic axi_rd(input logic [11:0] a);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic wait_pd(input logic lvl);
    int n;
    for (n = 0; n < 3000 && power_down_n !== lvl; n++) @(posedge aclk);
    if (n == 3000) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic t_powerup;
    axi_rd(`HBCTL_OFF_CTRL);
    chk("ctrl reset", 32'h0, rd);
    axi_rd(`HBCTL_OFF_RECOV);
    chk("recov reset", 32'h0000_0064, rd);
    axi_wr(`HBCTL_OFF_CTRL, 32'h1);
    chk("float held", 32'h0, {31'h0, power_down_n});
    chk("switches off", 32'h0, {24'h0, sw});
    wait_pd(1'b1);
    chk("settle length", `HBCTL_SETTLE_CYC + 1, cyc);
  endtask
  task automatic t_decode;
    for (int i = 0; i < 3; i++) begin
      axi_wr(`HBCTL_OFF_DRIVE, {28'h0, 2'(i), 2'(2 - i)});
      repeat (3) @(posedge aclk);
      chk("drive pins", {28'h0, 2'(i), 2'(2 - i)}, {28'h0, drv});
      chk("switches", {24'h0, swx({2'(i), 2'(2 - i)})}, {24'h0, sw});
    end
    axi_wr(`HBCTL_OFF_IRQ_EN, 32'h4);
    axi_wr(`HBCTL_OFF_DRIVE, 32'hF);
    repeat (3) @(posedge aclk);
    chk("both high refused", 32'h0, {28'h0, drv});
    chk("bad code irq", 32'h1, {31'h0, irq});
    axi_wr(`HBCTL_OFF_CTRL, 32'h5);
    axi_wr(`HBCTL_OFF_DRIVE, 32'h8);
    repeat (3) @(posedge aclk);
    chk("parallel pins", 32'h1C, {27'h0, parallel_sel, drv});
    axi_wr(`HBCTL_OFF_CTRL, 32'h0);
    repeat (3) @(posedge aclk);
    chk("disabled", 32'h0, {23'h0, power_down_n, sw});
    axi_wr(`HBCTL_OFF_IRQ_CLR, 32'h4);
    axi_wr(`HBCTL_OFF_CTRL, 32'h1);
    axi_wr(`HBCTL_OFF_DRIVE, 32'h9);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  task automatic t_latched;
    axi_wr(`HBCTL_OFF_IRQ_EN, 32'h1);
    fault_cond <= 1'b1;
    @(posedge aclk);
    fault_cond <= 1'b0;
    @(posedge aclk);
    chk("fault off", 32'h0, {23'h0, fault_node, sw});
    wait_pd(1'b0);
    repeat (50) @(posedge aclk);
    chk("stays down", 32'h1, {30'h0, power_down_n, irq});
    axi_wr(`HBCTL_OFF_CTRL, 32'h9);
    wait_pd(1'b1);
    @(posedge aclk);
    chk("restarted", {24'h1, swx(4'h9)}, {23'h0, fault_node, sw});
    axi_wr(`HBCTL_OFF_IRQ_CLR, 32'h1);
    repeat (3) @(posedge aclk);
    chk("fault irq clear", 32'h0, {31'h0, irq});
  endtask
  task automatic t_auto;
    int rises, oe_low;
    logic last;
    rises = 0;
    oe_low = 0;
    last = 1'b1;
    axi_wr(`HBCTL_OFF_RECOV, 32'h14);
    axi_wr(`HBCTL_OFF_CTRL, 32'h3);
    fault_cond <= 1'b1;
    repeat (400) begin
      @(posedge aclk);
      if (power_down_n && !last) rises++;
      if (!fault_n_oe) oe_low++;
      last = power_down_n;
    end
    chk("retry seen", 32'h1, {31'h0, rises >= 2});
    chk("node pulled", 32'h1, {31'h0, oe_low >= 20});
    fault_cond <= 1'b0;
    repeat (100) @(posedge aclk);
    chk("recovered", {24'h1, swx(4'h9)}, {23'h0, power_down_n, sw});
    axi_wr(`HBCTL_OFF_CTRL, 32'h1);
    axi_wr(`HBCTL_OFF_IRQ_CLR, 32'hF);
  endtask
  task automatic t_misc;
    axi_wr(`HBCTL_OFF_IRQ_EN, 32'h2);
    hot <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(`HBCTL_OFF_IRQ_STAT);
    chk("warn event", 32'h3, {30'h0, rd[1], irq});
    hot <= 1'b0;
    axi_wr(`HBCTL_OFF_IRQ_CLR, 32'h2);
    repeat (3) @(posedge aclk);
    chk("warn cleared", 32'h0, {31'h0, irq});
    undervolt <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    chk("uv lockout", 32'h0, {24'h0, sw});
    undervolt <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    chk("uv recover", {24'h0, swx(4'h9)}, {24'h0, sw});
    axi_rd(12'h100);
    chk("unmapped read", 32'h2, {rd[29:0], resp});
    axi_wr(12'h100, 32'h1);
    chk("unmapped write", 32'h2, {30'h0, resp});
  endtask
  // mid-run reset: pins drop to safe levels, then the settle phase starts over
  task automatic t_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("reset pins", 32'h1, {25'h0, drv, power_down_n, irq, fault_n_oe});
    aresetn <= 1'b1;
    axi_rd(`HBCTL_OFF_CTRL);
    chk("ctrl after reset", 32'h0, rd);
    chk("float after reset", 32'h0, {31'h0, power_down_n});
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {fault_cond, hot, undervolt} = 3'h0;
    mismatches = 0;
    compares = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_powerup();
    t_decode();
    t_latched();
    t_auto();
    t_misc();
    t_reset();
    complete_run();
  end
endmodule // test_half_bridge_gate_decode_fault
